// ### hdl/scrc_clkgen.v
`timescale 1ns/1ps
`include "scrc_map.vh"

module scrc_clkgen (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire want_pll,
    input wire [1:0] div_sel,
    output reg src_pll_r,
    output reg cpu_clk_en_r,
    output reg periph_clk_en_r
);

reg [1:0] gap_cnt_r;
reg [1:0] div_cnt_r;
reg [1:0] div_cur_r;
reg [1:0] div_last;

// ----------------------------------------------------------------
// Divider terminal count for the ratio in force
// ----------------------------------------------------------------
always @* begin
    case (div_cur_r)
        `SCRC_DIV_FULL: div_last = 2'h0;
        `SCRC_DIV_HALF: div_last = 2'h1;
        default: div_last = 2'h3;
    endcase
end

// ----------------------------------------------------------------
// Source switch: gate off, flip, gate on, so no runt pulse escapes
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        src_pll_r <= 1'b0;
        gap_cnt_r <= 2'h0;
        cpu_clk_en_r <= 1'b0;
    end else begin
        if (want_pll != src_pll_r) begin
            cpu_clk_en_r <= 1'b0;
            if (gap_cnt_r == `SCRC_SW_GAP) begin
                src_pll_r <= want_pll;
                gap_cnt_r <= 2'h0;
            end else begin
                gap_cnt_r <= gap_cnt_r + 2'h1;
            end
        end else begin
            gap_cnt_r <= 2'h0;
            cpu_clk_en_r <= run;
        end
    end
end

// ----------------------------------------------------------------
// Peripheral divider; new ratio taken only at a period boundary
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        div_cnt_r <= 2'h0;
        div_cur_r <= `SCRC_DIV_QUARTER;
        periph_clk_en_r <= 1'b0;
    end else begin
        periph_clk_en_r <= 1'b0;
        if (div_cnt_r == div_last) begin
            div_cnt_r <= 2'h0;
            div_cur_r <= (div_sel == 2'h3) ? div_cur_r : div_sel;
            periph_clk_en_r <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + 2'h1;
        end
    end
end

endmodule

// ### hdl/scrc_map.vh
`ifndef SCRC_MAP_VH
`define SCRC_MAP_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCRC_CLK_MHZ 16'h0028
`define SCRC_PLL_LOCK_US 16'h0064
`define SCRC_PLL_LOCK_CYC (`SCRC_PLL_LOCK_US * `SCRC_CLK_MHZ)
`define SCRC_WAKE_CYC 16'h0800
`define SCRC_FOSC_KHZ 12000
`define SCRC_LCO_MIN_KHZ 156000
`define SCRC_LCO_MAX_KHZ 320000
`define SCRC_SW_GAP 2

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define SCRC_NPERIPH 12
`define SCRC_NEINT 9
`define SCRC_NLINE 4

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SCRC_OFS_PLL_CTRL 12'h000
`define SCRC_OFS_PLL_CFG 12'h004
`define SCRC_OFS_PLL_STAT 12'h008
`define SCRC_OFS_PWR_CTRL 12'h010
`define SCRC_OFS_PERIPH_PWR 12'h014
`define SCRC_OFS_BUS_DIV 12'h018
`define SCRC_OFS_MEM_MAP 12'h01c
`define SCRC_OFS_EINT_MODE 12'h020
`define SCRC_OFS_EINT_ROUTE 12'h024
`define SCRC_OFS_EINT_WAKE 12'h028
`define SCRC_OFS_EINT_FLAG 12'h02c
`define SCRC_OFS_RST_STAT 12'h030

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SCRC_PLL_EN_BIT 0
`define SCRC_PLL_CON_BIT 1
`define SCRC_PWR_IDLE_BIT 0
`define SCRC_PWR_PD_BIT 1
`define SCRC_DIV_QUARTER 2'h0
`define SCRC_DIV_FULL 2'h1
`define SCRC_DIV_HALF 2'h2
`define SCRC_PERIPH_RST 12'hfff
`define SCRC_ROUTE_RST 18'h0_0000
`define SCRC_MAP_FLASH 1'b1
`define SCRC_RESET_VECTOR 32'h0000_0000

`endif

// ### hdl/scrc_top.v
// Behaviour
// - Loop multiplier accepts 1 through 32.
// - Output divider is 2, 4, 8, 16.
// - Oscillator held within 156..320 MHz.
// - Reset leaves loop off and bypassed.
// - Loop locks within 100 microseconds.
// - CPU clock uses loop only when running+connected.
// - Reset pin or watchdog raises chip reset.
// - Reset held through pin, oscillator, count, flash.
// - Processor starts at address zero after reset.
// - Wake-up timer watches crystal oscillator for stability.
// - Power-down exit passes the wake-up timer.
// - Nine interrupt pins route to four lines.
// - Each interrupt pin may wake from power-down.
// - Vector region served from flash or RAM.
// - Idle halts processor clock until interrupt/reset.
// - Power-down stops oscillator, keeps all state.
// - Power-down left only by reset or interrupt.
// - Each peripheral clock individually switchable.
// - Peripheral clock full, half, quarter; quarter default.
// - Loop keeps running through idle mode.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "scrc_map.vh"

module scrc_top #(
    parameter [15:0] WAKE_CYCLES = `SCRC_WAKE_CYC,
    parameter [15:0] LOCK_CYCLES = `SCRC_PLL_LOCK_CYC,
    parameter [31:0] FOSC_KHZ = `SCRC_FOSC_KHZ
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    input wire ext_reset_n_pin,
    input wire wdt_reset_req,
    input wire osc_running_pin,
    input wire flash_init_done,
    input wire periph_irq_any,
    input wire [`SCRC_NEINT-1:0] eint_pin,
    output reg sys_reset_n_r,
    output reg [31:0] cpu_start_addr_r,
    output reg osc_enable_r,
    output reg pll_power_r,
    output reg [4:0] pll_mult_m1_r,
    output reg [1:0] pll_div_sel_r,
    output wire cpu_src_pll,
    output wire cpu_clk_en,
    output wire periph_clk_en,
    output reg [`SCRC_NPERIPH-1:0] periph_clk_on_r,
    output reg vector_in_flash_r,
    output reg [`SCRC_NLINE-1:0] eint_irq_r
);

localparam [6:0] ST_HOLD = 7'b000_0001;
localparam [6:0] ST_OSC = 7'b000_0010;
localparam [6:0] ST_FLASH = 7'b000_0100;
localparam [6:0] ST_RUN = 7'b000_1000;
localparam [6:0] ST_IDLE = 7'b001_0000;
localparam [6:0] ST_PD = 7'b010_0000;
localparam [6:0] ST_WAKE = 7'b100_0000;

localparam NE = `SCRC_NEINT;

// Loop cannot lock if its oscillator would leave the legal band
function lco_ok;
    input [4:0] m1;
    input [1:0] ps;
    reg [31:0] lco;
    begin
        lco = FOSC_KHZ * ({27'h0, m1} + 32'h1) * (32'h2 << ps);
        lco_ok = (lco >= `SCRC_LCO_MIN_KHZ) && (lco <= `SCRC_LCO_MAX_KHZ);
    end
endfunction

reg [6:0] state_r;
reg [6:0] state_nxt;
reg [15:0] wake_cnt_r;
reg [15:0] lock_cnt_r;
reg pll_en_r;
reg pll_con_r;
reg pll_lock_r;
reg [`SCRC_NPERIPH-1:0] periph_on_r;
reg [1:0] bus_div_r;
reg map_flash_r;
reg [NE-1:0] eint_edge_mode_r;
reg [2*NE-1:0] eint_route_r;
reg [NE-1:0] eint_wake_en_r;
reg [NE-1:0] eint_flag_r;
reg [1:0] rst_stat_r;
reg [NE-1:0] eint_meta_r;
reg [NE-1:0] eint_sync_r;
reg [NE-1:0] eint_prev_r;
reg [1:0] rst_pin_sync_r;
reg [1:0] osc_sync_r;
reg [NE-1:0] eint_active;
reg [`SCRC_NLINE-1:0] line_req;
reg [31:0] rd_data;
reg rd_hit;
integer k;

wire chip_rst = !rst_pin_sync_r[1] || wdt_reset_req;
wire osc_ok = osc_sync_r[1];
wire acc = psel && penable && pready_r;
wire wr_en = acc && pwrite;
wire soft_rst = (state_r == ST_HOLD);
wire wake_done = osc_ok && (wake_cnt_r >= WAKE_CYCLES);
wire [NE-1:0] eint_rise = eint_sync_r & ~eint_prev_r;
wire pd_wake = |(eint_sync_r & eint_wake_en_r);
wire pll_run = pll_power_r && lco_ok(pll_mult_m1_r, pll_div_sel_r);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rst_pin_sync_r <= 2'h3; // Pin idle level
        osc_sync_r <= 2'h0;
        eint_meta_r <= {NE{1'b0}};
        eint_sync_r <= {NE{1'b0}};
        eint_prev_r <= {NE{1'b0}};
    end else begin
        rst_pin_sync_r <= {rst_pin_sync_r[0], ext_reset_n_pin};
        osc_sync_r <= {osc_sync_r[0], osc_running_pin};
        eint_meta_r <= eint_pin;
        eint_sync_r <= eint_meta_r;
        eint_prev_r <= eint_sync_r;
    end
end

// ----------------------------------------------------------------
// Reset and power sequencer
// ----------------------------------------------------------------
always @* begin
    state_nxt = state_r;
    case (state_r)
        ST_HOLD: if (!chip_rst) state_nxt = ST_OSC;
        ST_OSC: if (wake_done) state_nxt = ST_FLASH;
        ST_FLASH: if (flash_init_done) state_nxt = ST_RUN;
        ST_RUN: begin
            if (wr_en && paddr == `SCRC_OFS_PWR_CTRL) begin
                if (pwdata[`SCRC_PWR_PD_BIT])
                    state_nxt = ST_PD;
                else if (pwdata[`SCRC_PWR_IDLE_BIT])
                    state_nxt = ST_IDLE;
            end
        end
        // Any peripheral or external request resumes execution
        ST_IDLE: if (periph_irq_any || (|line_req)) state_nxt = ST_RUN;
        ST_PD: if (pd_wake) state_nxt = ST_WAKE;
        ST_WAKE: if (wake_done) state_nxt = ST_RUN;
        default: state_nxt = ST_HOLD;
    endcase
    if (chip_rst)
        state_nxt = ST_HOLD;
end

// Wake count runs only on a running oscillator
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_r <= ST_HOLD;
        wake_cnt_r <= 16'h0000;
        sys_reset_n_r <= 1'b0;
        osc_enable_r <= 1'b1;
        cpu_start_addr_r <= `SCRC_RESET_VECTOR;
    end else begin
        state_r <= state_nxt;
        if (!osc_ok || state_r == ST_HOLD || state_r == ST_PD)
            wake_cnt_r <= 16'h0000;
        else if (wake_cnt_r < WAKE_CYCLES)
            wake_cnt_r <= wake_cnt_r + 16'h0001;
        sys_reset_n_r <= (state_nxt != ST_HOLD) && (state_nxt != ST_OSC)
            && (state_nxt != ST_FLASH);
        osc_enable_r <= (state_nxt != ST_PD);
        if (state_r == ST_FLASH)
            cpu_start_addr_r <= `SCRC_RESET_VECTOR;
    end
end

// ----------------------------------------------------------------
// Loop control and lock timer
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lock_cnt_r <= 16'h0000;
        pll_lock_r <= 1'b0;
        pll_power_r <= 1'b0;
    end else begin
        // Stays powered through idle, dropped in power-down and in reset hold
        pll_power_r <= pll_en_r && (state_nxt != ST_PD) && !soft_rst;
        if (!pll_run || (wr_en && paddr == `SCRC_OFS_PLL_CFG)) begin
            lock_cnt_r <= 16'h0000;
            pll_lock_r <= 1'b0;
        end else if (lock_cnt_r >= LOCK_CYCLES - 16'h0001) begin
            pll_lock_r <= 1'b1;
        end else begin
            lock_cnt_r <= lock_cnt_r + 16'h0001;
        end
    end
end

// ----------------------------------------------------------------
// Software registers
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pll_en_r <= 1'b0;
        pll_con_r <= 1'b0;
        pll_mult_m1_r <= 5'h00;
        pll_div_sel_r <= 2'h0;
        periph_on_r <= `SCRC_PERIPH_RST;
        bus_div_r <= `SCRC_DIV_QUARTER;
        map_flash_r <= `SCRC_MAP_FLASH;
        eint_edge_mode_r <= {NE{1'b0}};
        eint_route_r <= `SCRC_ROUTE_RST;
        eint_wake_en_r <= {NE{1'b0}};
    end else if (soft_rst) begin
        pll_en_r <= 1'b0;
        pll_con_r <= 1'b0;
        pll_mult_m1_r <= 5'h00;
        pll_div_sel_r <= 2'h0;
        periph_on_r <= `SCRC_PERIPH_RST;
        bus_div_r <= `SCRC_DIV_QUARTER;
        map_flash_r <= `SCRC_MAP_FLASH;
        eint_edge_mode_r <= {NE{1'b0}};
        eint_route_r <= `SCRC_ROUTE_RST;
        eint_wake_en_r <= {NE{1'b0}};
    end else if (wr_en) begin
        case (paddr)
            `SCRC_OFS_PLL_CTRL: begin
                pll_en_r <= pwdata[`SCRC_PLL_EN_BIT];
                pll_con_r <= pwdata[`SCRC_PLL_CON_BIT];
            end
            `SCRC_OFS_PLL_CFG: begin
                pll_mult_m1_r <= pwdata[4:0];
                pll_div_sel_r <= pwdata[6:5];
            end
            `SCRC_OFS_PERIPH_PWR: periph_on_r <= pwdata[`SCRC_NPERIPH-1:0];
            `SCRC_OFS_BUS_DIV: bus_div_r <= pwdata[1:0];
            `SCRC_OFS_MEM_MAP: map_flash_r <= pwdata[0];
            `SCRC_OFS_EINT_MODE: eint_edge_mode_r <= pwdata[NE-1:0];
            `SCRC_OFS_EINT_ROUTE: eint_route_r <= pwdata[2*NE-1:0];
            `SCRC_OFS_EINT_WAKE: eint_wake_en_r <= pwdata[NE-1:0];
            default: ;
        endcase
    end
end

// Sticky flags: a new event in the clearing cycle survives
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        eint_flag_r <= {NE{1'b0}};
        rst_stat_r <= 2'h0;
    end else begin
        if (wr_en && paddr == `SCRC_OFS_EINT_FLAG)
            eint_flag_r <= (eint_flag_r & ~pwdata[NE-1:0]) | eint_rise;
        else
            eint_flag_r <= eint_flag_r | eint_rise;
        if (wr_en && paddr == `SCRC_OFS_RST_STAT)
            rst_stat_r <= (rst_stat_r & ~pwdata[1:0])
                | {wdt_reset_req, !rst_pin_sync_r[1]};
        else
            rst_stat_r <= rst_stat_r | {wdt_reset_req, !rst_pin_sync_r[1]};
    end
end

// ----------------------------------------------------------------
// External interrupt steering
// ----------------------------------------------------------------
genvar g;
generate
    for (g = 0; g < NE; g = g + 1) begin : g_eint
        always @* begin
            eint_active[g] = eint_edge_mode_r[g] ? eint_flag_r[g] : eint_sync_r[g];
        end
    end
endgenerate

always @* begin
    line_req = {`SCRC_NLINE{1'b0}};
    for (k = 0; k < NE; k = k + 1)
        line_req[eint_route_r[2*k +: 2]] = line_req[eint_route_r[2*k +: 2]]
            | eint_active[k];
end

// Outputs that follow configuration
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        eint_irq_r <= {`SCRC_NLINE{1'b0}};
        periph_clk_on_r <= {`SCRC_NPERIPH{1'b0}};
        vector_in_flash_r <= `SCRC_MAP_FLASH;
    end else begin
        eint_irq_r <= line_req;
        // No peripheral clock at all in power-down; state is kept
        periph_clk_on_r <= (state_nxt == ST_PD) ? {`SCRC_NPERIPH{1'b0}}
            : periph_on_r;
        vector_in_flash_r <= map_flash_r;
    end
end

// ----------------------------------------------------------------
// Clock source selection and peripheral divider
// ----------------------------------------------------------------
scrc_clkgen u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_r == ST_RUN),
    .want_pll(pll_con_r && pll_lock_r && pll_power_r),
    .div_sel(bus_div_r),
    .src_pll_r(cpu_src_pll),
    .cpu_clk_en_r(cpu_clk_en),
    .periph_clk_en_r(periph_clk_en)
);

// ----------------------------------------------------------------
// APB slave: one wait state, unmapped reads zero with error
// ----------------------------------------------------------------
always @* begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
        `SCRC_OFS_PLL_CTRL: rd_data = {30'h0, pll_con_r, pll_en_r};
        `SCRC_OFS_PLL_CFG: rd_data = {25'h0, pll_div_sel_r, pll_mult_m1_r};
        `SCRC_OFS_PLL_STAT: rd_data = {20'h0, lco_ok(pll_mult_m1_r, pll_div_sel_r),
            pll_lock_r, pll_con_r, pll_en_r, 1'b0, pll_div_sel_r, pll_mult_m1_r};
        `SCRC_OFS_PWR_CTRL: rd_data = {30'h0, state_r == ST_PD, state_r == ST_IDLE};
        `SCRC_OFS_PERIPH_PWR: rd_data = {20'h0, periph_on_r};
        `SCRC_OFS_BUS_DIV: rd_data = {30'h0, bus_div_r};
        `SCRC_OFS_MEM_MAP: rd_data = {31'h0, map_flash_r};
        `SCRC_OFS_EINT_MODE: rd_data = {23'h0, eint_edge_mode_r};
        `SCRC_OFS_EINT_ROUTE: rd_data = {14'h0, eint_route_r};
        `SCRC_OFS_EINT_WAKE: rd_data = {23'h0, eint_wake_en_r};
        `SCRC_OFS_EINT_FLAG: rd_data = {23'h0, eint_flag_r};
        `SCRC_OFS_RST_STAT: rd_data = {30'h0, rst_stat_r};
        default: rd_hit = 1'b0;
    endcase
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h0000_0000;
    end else begin
        pready_r <= psel && penable && !pready_r;
        if (psel && penable && !pready_r) begin
            pslverr_r <= !rd_hit;
            prdata_r <= pwrite ? 32'h0000_0000 : rd_data;
        end else begin
            pslverr_r <= 1'b0;
        end
    end
end

endmodule

// ### verification/scrc_monitor.sv
`timescale 1ns/1ps
`include "scrc_map.vh"

module scrc_monitor (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata_r,
    input wire pready_r,
    input wire pslverr_r,
    input wire ext_reset_n_pin,
    input wire wdt_reset_req,
    input wire osc_running_pin,
    input wire flash_init_done,
    input wire sys_reset_n_r,
    input wire [31:0] cpu_start_addr_r,
    input wire osc_enable_r,
    input wire pll_power_r,
    input wire cpu_src_pll,
    input wire cpu_clk_en,
    input wire [`SCRC_NPERIPH-1:0] periph_clk_on_r
);
    // ------------
    // Properties
    // ------------
    // One clock domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_APB_LATENCY: assert property (psel && !penable ##1 psel && penable
        |-> !pready_r ##1 pready_r) else $error("pready timing");
    AST_READY_PULSE: assert property (pready_r |=> !pready_r)
        else $error("pready held");
    AST_ERR_DATA: assert property (pslverr_r |-> pready_r && prdata_r == 32'h0000_0000)
        else $error("bad error response");
    AST_RESET_BYPASS: assert property (
        !sys_reset_n_r [*5] |-> !pll_power_r && !cpu_src_pll) else $error("loop active in reset");
    AST_SRC_RUNNING: assert property (
        cpu_clk_en && cpu_src_pll |-> pll_power_r) else $error("cpu on loop while loop off");
    // Pin, oscillator and flash ready first
    AST_RELEASE: assert property (
        $rose(sys_reset_n_r) |-> $past(flash_init_done) && $past(osc_running_pin, 3)
        && $past(ext_reset_n_pin, 3)) else $error("reset released too early");
    AST_WDT_RESET: assert property (
        wdt_reset_req |-> ##[1:4] !sys_reset_n_r) else $error("watchdog gave no reset");
    AST_PIN_RESET: assert property (
        $fell(ext_reset_n_pin) |-> ##[1:5] !sys_reset_n_r) else $error("pin gave no reset");
    AST_START_ADDR: assert property (
        $rose(sys_reset_n_r) |-> cpu_start_addr_r == `SCRC_RESET_VECTOR)
        else $error("start address not zero");
    AST_PD_STOPPED: assert property (
        !osc_enable_r |-> !pll_power_r && periph_clk_on_r == '0)
        else $error("clocks alive in power-down");
    // Processor clock held off for eight cycles after the oscillator is re-enabled
    AST_WAKE_TIMER: assert property (
        $rose(osc_enable_r) |-> !cpu_clk_en [*8]) else $error("wake skipped timer");
endmodule

bind scrc_top scrc_monitor scrc_monitor_i (.pclk, .presetn,
    .psel, .penable, .prdata_r, .pready_r, .pslverr_r, .ext_reset_n_pin, .wdt_reset_req,
    .osc_running_pin, .flash_init_done, .sys_reset_n_r, .cpu_start_addr_r, .osc_enable_r,
    .pll_power_r, .cpu_src_pll, .cpu_clk_en, .periph_clk_on_r);

// ### verification/scrc_top_tb_top.sv
`timescale 1ns/1ps
`include "scrc_map.vh"

module scrc_top_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic ext_reset_n_pin = 1, wdt_reset_req = 0, periph_irq_any = 0, er;
    logic [8:0] eint_pin = 0;
    wire [31:0] prdata_r, cpu_start_addr_r;
    wire pready_r, pslverr_r, osc_running_pin, flash_init_done, sys_reset_n_r, osc_enable_r;
    wire pll_power_r, cpu_src_pll, cpu_clk_en, periph_clk_en, vector_in_flash_r;
    wire [4:0] pll_mult_m1_r;
    wire [1:0] pll_div_sel_r;
    wire [11:0] periph_clk_on_r;
    wire [3:0] eint_irq_r;
    int failures = 0, n_checks = 0, k;

    // 40 MHz clock
    always #12.5 pclk = ~pclk;

    scrc_top #(.WAKE_CYCLES(16'd8), .LOCK_CYCLES(16'd10)) scrc_top_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r, .pready_r,
        .pslverr_r, .ext_reset_n_pin, .wdt_reset_req, .osc_running_pin, .flash_init_done,
        .periph_irq_any, .eint_pin, .sys_reset_n_r, .cpu_start_addr_r, .osc_enable_r,
        .pll_power_r, .pll_mult_m1_r, .pll_div_sel_r, .cpu_src_pll, .cpu_clk_en,
        .periph_clk_en, .periph_clk_on_r, .vector_in_flash_r, .eint_irq_r);

    scrc_xtal_model scrc_xtal_model_i (.pclk, .osc_enable(osc_enable_r),
        .sys_reset_n(sys_reset_n_r), .osc_running(osc_running_pin),
        .flash_done(flash_init_done));

    // ------------
    // Tasks
    // ------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timeout(input string what);
        failures++;
        $display("ERROR %s expected answer seen timeout", what);
        report_and_stop();
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Request held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_r !== 1'b1 && n < 20);
        if (n >= 20) timeout("pready");
        rd = prdata_r;
        er = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rd);
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return sys_reset_n_r;
            1: return cpu_clk_en;
            2: return osc_enable_r;
            3: return cpu_src_pll;
            default: return eint_irq_r[2];
        endcase
    endfunction

    task automatic wait_for(input int s, input logic v);
        int n = 0;
        while (sig(s) !== v && n < 600) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 600) timeout("wait");
    endtask

    // Enable pulses in 16 cycles
    task automatic count_div(input logic [31:0] sel, input int exp);
        int n = 0;
        wr(`SCRC_OFS_BUS_DIV, sel);
        step(8);
        repeat (16) begin
            @(posedge pclk);
            n += (periph_clk_en === 1'b1);
        end
        check("pclk pulses", exp, n);
    endtask

    // ------------
    // Sequence
    // ------------
    initial begin
        step(8);
        presetn <= 1'b1;
        wait_for(0, 1'b1);
        check("src", 0, cpu_src_pll);
        check("start", `SCRC_RESET_VECTOR, cpu_start_addr_r);
        check("periph on", `SCRC_PERIPH_RST, periph_clk_on_r);
        check("vec", `SCRC_MAP_FLASH, vector_in_flash_r);
        rdc("div", `SCRC_OFS_BUS_DIV, `SCRC_DIV_QUARTER);
        $display("test reset done");
        count_div(`SCRC_DIV_FULL, 16);
        count_div(`SCRC_DIV_HALF, 8);
        count_div(`SCRC_DIV_QUARTER, 4);
        wr(`SCRC_OFS_BUS_DIV, 32'h0000_0003);
        rdc("div kept", `SCRC_OFS_BUS_DIV, 32'h0000_0003);
        $display("test divider done");
        // Out-of-band setting never locks
        wr(`SCRC_OFS_PLL_CFG, 32'h0000_007f);
        check("mult", 31, pll_mult_m1_r);
        check("odiv", 3, pll_div_sel_r);
        rdc("stat bad", `SCRC_OFS_PLL_STAT, 32'h0000_007f);
        wr(`SCRC_OFS_PLL_CFG, 32'h0000_0024);
        wr(`SCRC_OFS_PLL_CTRL, 32'h0000_0001);
        step(1);
        check("pll power", 1, pll_power_r);
        k = 0;
        do begin
            apb(1'b0, `SCRC_OFS_PLL_STAT, 32'h0000_0000);
            k++;
        end while (rd[10] !== 1'b1 && k < 8);
        check("stat lock", 32'h0000_0d24, rd);
        check("lock soon", 1, k <= 5);
        wr(`SCRC_OFS_PLL_CTRL, 32'h0000_0003);
        wait_for(3, 1'b1);
        wait_for(1, 1'b1);
        $display("test loop done");
        wr(`SCRC_OFS_PWR_CTRL, 32'h0000_0001);
        step(10);
        check("idle clk", 0, cpu_clk_en);
        check("idle loop", 1, pll_power_r);
        periph_irq_any <= 1'b1;
        wait_for(1, 1'b1);
        periph_irq_any <= 1'b0;
        rdc("mode", `SCRC_OFS_PWR_CTRL, 32'h0000_0000);
        $display("test idle done");
        wr(`SCRC_OFS_PERIPH_PWR, 32'h0000_05a5);
        wr(`SCRC_OFS_MEM_MAP, 32'h0000_0000);
        step(1);
        check("periph sel", 32'h0000_05a5, periph_clk_on_r);
        check("vec ram", 0, vector_in_flash_r);
        wr(`SCRC_OFS_MEM_MAP, 32'h0000_0001);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        check("vec flash", 1, vector_in_flash_r);
        check("unmapped err", 1, er);
        check("unmapped data", 0, rd);
        $display("test map done");
        // Pin 0 to line 2 level, pin 8 to line 3 edge
        wr(`SCRC_OFS_EINT_ROUTE, 32'h0003_0002);
        wr(`SCRC_OFS_EINT_MODE, 32'h0000_0100);
        wr(`SCRC_OFS_EINT_WAKE, 32'h0000_0001);
        eint_pin <= 9'h001;
        wait_for(4, 1'b1);
        check("level line", 4'h4, eint_irq_r);
        eint_pin <= 9'h100;
        step(2);
        eint_pin <= 9'h000;
        step(6);
        check("edge line", 4'h8, eint_irq_r);
        wr(`SCRC_OFS_EINT_FLAG, 32'h0000_0100);
        step(1);
        check("cleared", 4'h0, eint_irq_r);
        $display("test eint done");
        wr(`SCRC_OFS_PLL_CTRL, 32'h0000_0001);
        wait_for(3, 1'b0);
        wr(`SCRC_OFS_PWR_CTRL, 32'h0000_0002);
        step(2);
        check("pd osc", 0, osc_enable_r);
        check("pd periph", 0, periph_clk_on_r);
        eint_pin <= 9'h002;
        step(20);
        check("no wake", 0, osc_enable_r);
        eint_pin <= 9'h001;
        wait_for(2, 1'b1);
        wait_for(1, 1'b1);
        eint_pin <= 9'h000;
        check("kept periph", 32'h0000_05a5, periph_clk_on_r);
        check("no reset", 1, sys_reset_n_r);
        $display("test power-down done");
        wdt_reset_req <= 1'b1;
        step(2);
        wdt_reset_req <= 1'b0;
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        rdc("cause wdt", `SCRC_OFS_RST_STAT, 32'h0000_0002);
        rdc("div reset", `SCRC_OFS_BUS_DIV, `SCRC_DIV_QUARTER);
        check("periph reset", `SCRC_PERIPH_RST, periph_clk_on_r);
        wr(`SCRC_OFS_RST_STAT, 32'h0000_0002);
        ext_reset_n_pin <= 1'b0;
        step(20);
        check("pin hold", 0, sys_reset_n_r);
        ext_reset_n_pin <= 1'b1;
        wait_for(0, 1'b1);
        rdc("cause pin", `SCRC_OFS_RST_STAT, 32'h0000_0001);
        $display("test reset sources done");
        report_and_stop();
    end
endmodule

// ### verification/scrc_xtal_model.sv
`timescale 1ns/1ps

module scrc_xtal_model #(
    parameter int START_CYC = 6,
    parameter int FLASH_CYC = 4
) (
    input wire logic pclk,
    input wire logic osc_enable,
    input wire logic sys_reset_n,
    output logic osc_running,
    output logic flash_done
);
    int osc_cnt = 0, fl_cnt = 0;
    logic rst_q = 1'b0;

    // ------------
    // Crystal and flash
    // ------------
    // Crystal starts slowly, stops at once
    always @(posedge pclk) begin
        if (osc_enable !== 1'b1) begin
            osc_cnt <= 0;
        end else if (osc_cnt < START_CYC) begin
            osc_cnt <= osc_cnt + 1;
        end
    end
    assign osc_running = (osc_cnt >= START_CYC);

    // Flash redoes its init on every new chip reset
    always @(posedge pclk) begin
        rst_q <= sys_reset_n;
        if (rst_q && !sys_reset_n) begin
            fl_cnt <= 0;
        end else if (!sys_reset_n && osc_running && fl_cnt < FLASH_CYC) begin
            fl_cnt <= fl_cnt + 1;
        end
    end
    assign flash_done = (fl_cnt >= FLASH_CYC);
endmodule
